// ===== shared/ctpwm_pkg.sv
/*
 Package for the cascaded timer PWM / pulse generator block.
 Holds register indices, field positions, reset values and mode codes.
 Assumes a byte-wide register port with single-cycle strobes.
*/
package ctpwm_pkg;
   localparam logic [2:0] REG_PAIR_CTRL = 3'h0;
   localparam logic [2:0] REG_UPPER_CFG = 3'h1;
   localparam logic [2:0] REG_DUTY_LO = 3'h2;
   localparam logic [2:0] REG_DUTY_HI = 3'h3;
   localparam logic [2:0] REG_PERIOD_LO = 3'h4;
   localparam logic [2:0] REG_PERIOD_HI = 3'h5;
   localparam logic [2:0] REG_STATUS = 3'h6;
   localparam logic [2:0] REG_COUNT_LO = 3'h7;
   localparam int CTRL_RUN_POS = 2;
   localparam int CTRL_CAS_POS = 4;
   localparam int CFG_TCK_LSB = 0;
   localparam int CFG_EIN_POS = 3;
   localparam int CFG_MODE_LSB = 4;
   localparam int CFG_DBE_POS = 6;
   localparam int CFG_TFF_POS = 7;
   localparam logic [1:0] MODE_PWM12 = 2'h2;
   localparam logic [1:0] MODE_PPG16 = 2'h3;
   localparam logic [7:0] DUTY_RESET = 8'hFF;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [7:0] PWM_WRAP = 8'hFF;
   localparam logic [3:0] CYCLE_LAST = 4'hF;
   localparam int PRESCALE_W = 11;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } run_state_t;
endpackage

// ===== core/cascaded_timer_pwm_ppg.sv
/*
 Cascaded 16-bit timer: 12-bit PWM mode and 16-bit pulse generator mode.
 Assumes a synchronous register master on i_ref_clk and an external count
 clock pin that is asynchronous to it.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - PWM run clear stops, zeroes, restores level.
// - Buffer enable bit selects compare buffering.
// - Buffered duty loads every sixteenth overflow.
// - Buffered duty reads return buffer contents.
// - Stopped buffered write loads both copies.
// - Unbuffered write loads active compare immediately.
// - Value below counter waits for wrap.
// - Equal value matches right after write.
// - Unbuffered update during extra pulse acts immediately.
// - Source select picks prescaled gear clock.
// - Cascade bit joins timers, upper config rules.
// - Mode field 11 selects pulse generator.
// - External select chooses pin clock source.
// - Stopped output shows initial level select.
// - Generator duty match toggles output, lower interrupt.
// - Period match restores level, upper interrupt, clears.
// - Generator run clear stops, zeroes, restores level.
// - PWM toggles on low byte, overflow every 256.
// - Extra pulse bits delay toggle chosen cycles.
module cascaded_timer_pwm_ppg
   import ctpwm_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ext_clk,
   input wire logic i_slow_mode,
   output logic [7:0] o_rdata,
   output logic o_pwm_output_pin,
   output logic o_lower_interrupt,
   output logic o_upper_interrupt
);
   typedef struct packed {
      run_state_t st;
      logic [7:0] timer_pair_control;
      logic [7:0] upper_timer_config;
      logic [15:0] duty_buf;
      logic [15:0] period_buf;
      logic [7:0] duty_lo_stage;
      logic [15:0] period_stage;
      logic [15:0] duty_compare_value;
      logic [15:0] period_compare_value;
      logic [15:0] count;
      logic [3:0] cycle;
      logic out_lvl;
      logic toggled;
      logic lo_irq;
      logic hi_irq;
      logic lo_flag;
      logic hi_flag;
      logic [PRESCALE_W-1:0] pre;
      logic [2:0] ext_sync;
      logic [7:0] rdata;
   } state_t;

   state_t q;
   state_t n;

   function automatic logic extra_cycle(input logic [3:0] bits, input logic [3:0] cyc);
      logic [4:0] c;
      c = {1'b0, cyc} + 5'h01;
      extra_cycle = (bits[0] && c == 5'h09) ||
         (bits[1] && (c == 5'h05 || c == 5'h0D)) ||
         (bits[2] && c[1:0] == 2'h3) ||
         (bits[3] && !c[0]);
   endfunction

   logic running;
   logic buf_en;
   logic tff;
   logic ppg_mode;
   logic src_tick;
   logic int_tick;
   logic ext_tick;
   logic duty_commit;
   logic [7:0] duty8;
   logic [3:0] extra_bits;
   logic [7:0] pwm_target;
   logic [PRESCALE_W-1:0] pre_next;

   assign running = q.st == ST_RUN;
   assign buf_en = q.upper_timer_config[CFG_DBE_POS];
   assign tff = q.upper_timer_config[CFG_TFF_POS];
   assign ppg_mode = q.upper_timer_config[CFG_MODE_LSB +: 2] == MODE_PPG16;
   // The 8-bit duty sits above the extra-pulse nibble, so the two never overlap.
   assign duty8 = q.duty_compare_value[11:4];
   assign extra_bits = q.duty_compare_value[3:0];
   assign pre_next = q.pre + PRESCALE_W'(1);
   assign ext_tick = q.ext_sync[1] && !q.ext_sync[2];
   assign duty_commit = i_wr && i_addr == REG_DUTY_HI;

   // Slow mode honours only the two slowest codes (0, 1) and the undivided code 7; codes 2 to 6 stall.
   always_comb
   begin
      case (q.upper_timer_config[CFG_TCK_LSB +: 3])
         3'h0: int_tick = pre_next[10:0] == 11'h000;
         3'h1: int_tick = pre_next[9:0] == 10'h000;
         3'h2: int_tick = !i_slow_mode && pre_next[7:0] == 8'h00;
         3'h3: int_tick = !i_slow_mode && pre_next[5:0] == 6'h00;
         3'h4: int_tick = !i_slow_mode && pre_next[3:0] == 4'h0;
         3'h5: int_tick = !i_slow_mode && pre_next[1:0] == 2'h0;
         3'h6: int_tick = !i_slow_mode && !pre_next[0];
         default: int_tick = 1'b1;
      endcase
   end

   // the pin clock is synchronised, so it must stay below half the clock.
   assign src_tick = q.upper_timer_config[CFG_EIN_POS] ? ext_tick : int_tick;

   // Each PWM period low byte gets an extra count in selected cycles.
   assign pwm_target = extra_cycle(extra_bits, q.cycle) ? duty8 + 8'h01 : duty8;

   always_comb
   begin
      n = q;
      n.lo_irq = 1'b0;
      n.hi_irq = 1'b0;
      n.ext_sync = {q.ext_sync[1:0], i_ext_clk};
      n.pre = pre_next;
      if (i_rd)
      begin
         if (i_addr == REG_PAIR_CTRL)
            n.rdata = q.timer_pair_control;
         else if (i_addr == REG_UPPER_CFG)
            n.rdata = q.upper_timer_config;
         else if (i_addr == REG_DUTY_LO)
            n.rdata = buf_en ? q.duty_buf[7:0] : q.duty_compare_value[7:0];
         else if (i_addr == REG_DUTY_HI)
            n.rdata = buf_en ? q.duty_buf[15:8] : q.duty_compare_value[15:8];
         else if (i_addr == REG_PERIOD_LO)
            n.rdata = q.period_buf[7:0];
         else if (i_addr == REG_PERIOD_HI)
            n.rdata = q.period_buf[15:8];
         else if (i_addr == REG_STATUS)
            n.rdata = {4'h0, q.cycle[1:0], q.hi_flag, q.lo_flag};
         else
            n.rdata = q.count[7:0];
      end
      else
         n.rdata = 8'h00;
      if (i_rd && i_addr == REG_STATUS)
      begin
         n.lo_flag = 1'b0;
         n.hi_flag = 1'b0;
      end
      if (i_wr)
      begin
         if (i_addr == REG_PAIR_CTRL)
            n.timer_pair_control = i_wdata;
         else if (i_addr == REG_UPPER_CFG && !running)
            n.upper_timer_config = i_wdata;
         else if (i_addr == REG_DUTY_LO)
            n.duty_lo_stage = i_wdata;
         else if (i_addr == REG_PERIOD_LO)
            n.period_stage[7:0] = i_wdata;
         else if (i_addr == REG_PERIOD_HI)
            n.period_stage[15:8] = i_wdata;
      end
      if (duty_commit)
      begin
         n.duty_buf = {i_wdata, q.duty_lo_stage};
         n.period_buf = q.period_stage;
         if (!buf_en || !running)
         begin
            n.duty_compare_value = {i_wdata, q.duty_lo_stage};
            n.period_compare_value = q.period_stage;
         end
      end
      case (q.st)
         ST_IDLE:
         begin
            n.count = COUNT_ZERO;
            n.cycle = 4'h0;
            n.toggled = 1'b0;
            n.out_lvl = tff;
            if (q.timer_pair_control[CTRL_RUN_POS] && q.timer_pair_control[CTRL_CAS_POS])
            begin
               n.st = ST_RUN;
               n.pre = '0;
            end
         end
         ST_RUN:
         begin
            if (!q.timer_pair_control[CTRL_RUN_POS] || !q.timer_pair_control[CTRL_CAS_POS])
            begin
               n.st = ST_IDLE;
               n.count = COUNT_ZERO;
               n.out_lvl = tff;
            end
            else if (ppg_mode)
            begin
               // Match is checked every clock so an equal new value hits at once.
               if (!q.toggled && q.count == q.duty_compare_value)
               begin
                  n.toggled = 1'b1;
                  n.out_lvl = !tff;
                  n.lo_irq = 1'b1;
               end
               if (src_tick)
               begin
                  if (q.count == q.period_compare_value)
                  begin
                     n.count = COUNT_ZERO;
                     n.out_lvl = tff;
                     n.toggled = 1'b0;
                     n.hi_irq = 1'b1;
                  end
                  else
                     n.count = q.count + 16'h0001;
               end
            end
            else
            begin
               if (!q.toggled && q.count[7:0] == pwm_target)
               begin
                  n.toggled = 1'b1;
                  n.out_lvl = !tff;
               end
               if (src_tick)
               begin
                  if (q.count[7:0] == PWM_WRAP)
                  begin
                     n.count = COUNT_ZERO;
                     n.out_lvl = tff;
                     n.toggled = 1'b0;
                     n.lo_irq = 1'b1;
                     n.cycle = q.cycle + 4'h1;
                     if (q.cycle == CYCLE_LAST)
                     begin
                        n.hi_irq = 1'b1;
                        if (buf_en)
                           n.duty_compare_value = duty_commit ?
                              {i_wdata, q.duty_lo_stage} : q.duty_buf;
                     end
                  end
                  else
                     n.count = q.count + 16'h0001;
               end
            end
            if (ppg_mode && src_tick && q.count == q.period_compare_value && buf_en)
            begin
               n.duty_compare_value = duty_commit ? {i_wdata, q.duty_lo_stage} : q.duty_buf;
               n.period_compare_value = duty_commit ? q.period_stage : q.period_buf;
            end
         end
         default:
            n.st = ST_IDLE;
      endcase
      // Hardware events win over a status read clear in the same cycle.
      if (n.lo_irq)
         n.lo_flag = 1'b1;
      if (n.hi_irq)
         n.hi_flag = 1'b1;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q <= '0;
         q.st <= ST_IDLE;
         q.timer_pair_control <= CTRL_RESET;
         q.upper_timer_config <= CFG_RESET;
         q.duty_buf <= {DUTY_RESET, DUTY_RESET};
         q.duty_lo_stage <= DUTY_RESET;
         q.duty_compare_value <= {DUTY_RESET, DUTY_RESET};
         q.period_buf <= {PERIOD_RESET, PERIOD_RESET};
         q.period_stage <= {PERIOD_RESET, PERIOD_RESET};
         q.period_compare_value <= {PERIOD_RESET, PERIOD_RESET};
      end
      else
         q <= n;
   end

   assign o_rdata = q.rdata;
   assign o_pwm_output_pin = q.out_lvl;
   assign o_lower_interrupt = q.lo_irq;
   assign o_upper_interrupt = q.hi_irq;

   a_stop_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      running && !q.timer_pair_control[CTRL_RUN_POS] |=> q.count == COUNT_ZERO && !running)
      else $error("stop did not clear counter");
   a_stop_level: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      running && !q.timer_pair_control[CTRL_RUN_POS] |=> o_pwm_output_pin == $past(tff))
      else $error("stop did not restore level");
   a_idle_level: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !running && $past(!running) |-> o_pwm_output_pin == $past(tff))
      else $error("idle output wrong");
   a_direct_load: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      duty_commit && !buf_en |=> q.duty_compare_value == {$past(i_wdata), $past(q.duty_lo_stage)})
      else $error("unbuffered load missing");
   a_buffer_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_rd && i_addr == REG_DUTY_HI && buf_en |=> o_rdata == $past(q.duty_buf[15:8]))
      else $error("buffered read wrong");
   a_period_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      running && ppg_mode && q.timer_pair_control[CTRL_RUN_POS] && src_tick &&
      q.timer_pair_control[CTRL_CAS_POS] &&
      q.count == q.period_compare_value |=> o_upper_interrupt && q.count == COUNT_ZERO)
      else $error("period match wrong");
   a_duty_irq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_lower_interrupt && ppg_mode && running |-> o_pwm_output_pin == !tff)
      else $error("duty toggle wrong");
   a_sixteenth: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_upper_interrupt && !ppg_mode |-> q.cycle == 4'h0 && o_lower_interrupt)
      else $error("upper interrupt not on sixteenth");
   c_ppg_cycle: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      ppg_mode && o_lower_interrupt ##[1:1000] o_upper_interrupt);
   c_pwm_wrap: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      !ppg_mode && o_upper_interrupt);
   c_stop: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      running ##1 !running);
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
/*
 Self-checking bench for the cascaded timer block: pulse generator and 12-bit PWM runs.
 Assumes the register map and one-cycle read latency of the block's package and notes.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ctpwm_pkg::*;
   typedef struct {logic [1:0] kind; int gap; logic pin;} ev_note_t;
   localparam int LIMIT = 20000;
   localparam logic [7:0] CAS = 8'(1 << CTRL_CAS_POS);
   localparam logic [7:0] GO = CAS | 8'(1 << CTRL_RUN_POS);
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_ext_clk = 1'b0;
   logic i_slow_mode = 1'b0;
   logic [15:0] pin16;
   logic [15:0] irq_pair;
   logic [1:0] ext_div = 2'h0;
   logic [7:0] o_rdata;
   logic o_pwm_output_pin;
   logic o_lower_interrupt;
   logic o_upper_interrupt;
   int n_fail = 0;
   int compares = 0;
   int cyc_n = 0;
   int last_ev = 0;
   int pin_cnt = 0;
   logic pin_exp = 1'b0;
   logic rd_pend = 1'b0;
   logic [31:0] seed = 32'hE1D2;
   logic [7:0] rd_q[$];
   ev_note_t ev_q[$];
   ev_note_t nt;

   always #20 i_ref_clk = ~i_ref_clk;

   assign pin16 = {15'h0, o_pwm_output_pin};
   assign irq_pair = {14'h0, o_upper_interrupt, o_lower_interrupt};

   cascaded_timer_pwm_ppg u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_clk(i_ext_clk),
      .i_slow_mode(i_slow_mode),
      .o_rdata(o_rdata), .o_pwm_output_pin(o_pwm_output_pin),
      .o_lower_interrupt(o_lower_interrupt), .o_upper_interrupt(o_upper_interrupt));

   // The pin clock has four reference cycles per phase, well above the two-cycle minimum.
   always @(posedge i_ref_clk)
   begin
      ext_div <= ext_div + 2'h1;
      if (ext_div == 2'h3) i_ext_clk <= ~i_ext_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // A hang anywhere ends here as a failure rather than running on.
   always @(posedge i_ref_clk)
   begin
      if (cyc_n == LIMIT)
      begin
         n_fail++;
         stop_test();
      end
   end

   // Outputs are sampled at the edge, so each sees the value settled in the cycle before.
   always @(posedge i_ref_clk)
   begin
      cyc_n++;
      if (rd_pend)
      begin
         if (rd_q.size() == 0) chk("unexpected read", 16'h0001, 16'h0000);
         else chk("read data", {8'h00, o_rdata}, {8'h00, rd_q.pop_front()});
      end
      rd_pend = i_rd;
      if (pin_cnt == 1)
         chk("pin level", pin16, {15'h0, pin_exp});
      if (pin_cnt != 0) pin_cnt--;
      if (o_lower_interrupt === 1'b1 || o_upper_interrupt === 1'b1)
      begin
         if (ev_q.size() == 0) chk("spurious interrupt", 16'h0001, 16'h0000);
         else
         begin
            nt = ev_q.pop_front();
            chk("irq kind", irq_pair, 16'(nt.kind));
            if (nt.gap != 0)
               chk("irq spacing", 16'(cyc_n - last_ev), 16'(nt.gap));
            pin_exp = nt.pin;
            pin_cnt = 2;
         end
         last_ev = cyc_n;
      end
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      @(posedge i_ref_clk);
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      i_addr <= a;
      i_rd <= 1'b1;
      i_wr <= 1'b0;
      @(posedge i_ref_clk);
   endtask

   task automatic idle(input int n);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (n) @(posedge i_ref_clk);
   endtask

   // Waits for every noted event; the caller stops at once, before the next duty match.
   task automatic drain;
      idle(1);
      while (ev_q.size() != 0) @(posedge i_ref_clk);
   endtask

   task automatic run_ppg(input logic [7:0] cfg, input int s);
      int p;
      int d;
      logic tff;
      seed = lfsr(seed);
      p = 12 + int'(seed[2:0]);
      d = 4 + int'(seed[4:3]);
      tff = cfg[CFG_TFF_POS];
      wr(REG_UPPER_CFG, cfg);
      wr(REG_PERIOD_LO, 8'(p));
      wr(REG_PERIOD_HI, 8'h00);
      wr(REG_DUTY_LO, 8'(d));
      wr(REG_DUTY_HI, 8'h00);
      ev_q.push_back('{2'b01, 0, ~tff});
      // The duty match follows the tick by one clock; the period match lands on the tick.
      for (int k = 0; k < 3; k++)
      begin
         ev_q.push_back('{2'b10, (p - d + 1) * s - 1, tff});
         if (k < 2) ev_q.push_back('{2'b01, d * s + 1, ~tff});
      end
      wr(REG_PAIR_CTRL, GO);
      idle(1);
      wr(REG_UPPER_CFG, 8'h00);
      drain();
      wr(REG_PAIR_CTRL, CAS);
      idle(3);
      chk("stopped level", {15'h0, o_pwm_output_pin}, {15'h0, tff});
      rd(REG_COUNT_LO, 8'h00);
      rd(REG_UPPER_CFG, cfg);
      rd(REG_STATUS, 8'h03);
      rd(REG_STATUS, 8'h00);
      idle(2);
   endtask

   initial
   begin
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rd(REG_DUTY_LO, DUTY_RESET);
      rd(REG_DUTY_HI, DUTY_RESET);
      rd(REG_PERIOD_LO, PERIOD_RESET);
      rd(REG_PERIOD_HI, PERIOD_RESET);
      rd(REG_PAIR_CTRL, CTRL_RESET);
      rd(REG_UPPER_CFG, CFG_RESET);
      rd(REG_STATUS, 8'h00);
      wr(REG_UPPER_CFG, 8'(1 << CFG_TFF_POS));
      idle(3);
      chk("idle level high", {15'h0, o_pwm_output_pin}, 16'h0001);
      wr(REG_UPPER_CFG, 8'h00);
      idle(3);
      chk("idle level low", {15'h0, o_pwm_output_pin}, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         run_ppg({i[0], i[1], MODE_PPG16, i == 3, 3'(7 - i)}, (i == 3) ? 8 : (1 << i));
      end
      // Slow mode stalls a fast source code; normal mode would tick once in 256 clocks.
      i_slow_mode <= 1'b1;
      wr(REG_UPPER_CFG, {2'b00, MODE_PPG16, 1'b0, 3'h2});
      wr(REG_PAIR_CTRL, GO);
      idle(300);
      rd(REG_COUNT_LO, 8'h00);
      wr(REG_PAIR_CTRL, CAS);
      rd(REG_STATUS, 8'h00);
      i_slow_mode <= 1'b0;
      wr(REG_UPPER_CFG, {1'b0, 1'b1, MODE_PWM12, 1'b0, 3'h7});
      wr(REG_DUTY_LO, 8'h40);
      wr(REG_DUTY_HI, 8'h00);
      ev_q.push_back('{2'b01, 0, 1'b0});
      for (int k = 0; k < 15; k++)
      begin
         ev_q.push_back('{(k == 14) ? 2'b11 : 2'b01, 256, 1'b0});
      end
      wr(REG_PAIR_CTRL, GO);
      wr(REG_DUTY_LO, 8'h90);
      wr(REG_DUTY_HI, 8'h00);
      rd(REG_DUTY_LO, 8'h90);
      rd(REG_DUTY_HI, 8'h00);
      drain();
      wr(REG_PAIR_CTRL, CAS);
      idle(3);
      chk("pwm stopped level", {15'h0, o_pwm_output_pin}, 16'h0000);
      rd(REG_COUNT_LO, 8'h00);
      idle(3);
      stop_test();
   end
endmodule
`default_nettype wire
